// file: rtl/pnr_nextpage_irq_regs.sv
// management-interface slave holding the per-port next-page words and the shared interrupt register
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module pnr_nextpage_irq_regs
  import pnr_pkg::*;
#(
  parameter logic [4:0] PHY_BASE = 5'h00
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mdc,
  input wire logic mdioIn,
  output var logic mdioOut,
  output var logic mdioOe,
  input wire logic [NUM_PORTS-1:0] pageSent,
  input wire pnr_port_stat_t portStat,
  output wire pnr_np_t [NUM_PORTS-1:0] npTxWord,
  output wire pnr_irq_t irqReg,
  output wire logic status_change_irq_n
);
  pnr_mdio_state_t s;
  pnr_mdio_state_t next_s;
  logic mdcRise;
  logic [11:0] hdrNext;
  logic rdHit;
  logic [15:0] rdData;
  logic [15:0] wrVal;
  logic [NUM_PORTS-1:0] npWr;
  logic irqWr;
  logic rdClr;

  // ==========================================================
  // frame engine
  always_comb begin
    mdcRise = mdc & ~s.mdcPrev;
    hdrNext = {s.hdr[10:0], mdioIn};
    wrVal = {s.shift[14:0], mdioIn};
    // upper address bits pick this device, lowest two pick the port
    rdHit = hdrNext[9:7] == PHY_BASE[4:2];
    rdData = 16'h0000;
    if (hdrNext[4:0] == REG_NP_TX) begin
      rdData = npTxWord[hdrNext[6:5]];
    end else if (hdrNext[4:0] == REG_IRQ) begin
      rdData = irqReg;
    end
    npWr = '0;
    irqWr = 1'b0;
    rdClr = 1'b0;
    next_s = s;
    next_s.mdcPrev = mdc;
    if (mdcRise) begin
      case (s.st)
        MS_PREAMBLE: begin
          if (mdioIn) begin
            if (s.preCnt != PREAMBLE_BITS) begin
              next_s.preCnt = s.preCnt + 6'h01;
            end
          end else begin
            next_s.st = (s.preCnt == PREAMBLE_BITS) ? MS_START : MS_PREAMBLE;
            next_s.preCnt = 6'h00;
          end
        end
        MS_START: begin
          next_s.bitCnt = 5'h00;
          next_s.st = mdioIn ? MS_HEADER : MS_PREAMBLE;
        end
        MS_HEADER: begin
          next_s.hdr = hdrNext;
          next_s.bitCnt = s.bitCnt + 5'h01;
          if (s.bitCnt == HDR_BITS - 5'h01) begin
            next_s.bitCnt = 5'h00;
            if (!rdHit) begin
              // frame for another device: wait out its tail in preamble
              next_s.st = MS_PREAMBLE;
            end else if (hdrNext[11:10] == OP_READ) begin
              next_s.st = MS_RD_TA;
              next_s.shift = rdData;
              rdClr = hdrNext[4:0] == REG_IRQ;
            end else if (hdrNext[11:10] == OP_WRITE) begin
              next_s.st = MS_WR_TA;
            end else begin
              next_s.st = MS_PREAMBLE;
            end
          end
        end
        MS_WR_TA: begin
          next_s.bitCnt = s.bitCnt + 5'h01;
          if (s.bitCnt == TA_BITS - 5'h01) begin
            next_s.bitCnt = 5'h00;
            next_s.st = MS_WR_DATA;
          end
        end
        MS_WR_DATA: begin
          next_s.shift = wrVal;
          next_s.bitCnt = s.bitCnt + 5'h01;
          if (s.bitCnt == DATA_BITS - 5'h01) begin
            next_s.bitCnt = 5'h00;
            next_s.st = MS_PREAMBLE;
            if (s.hdr[4:0] == REG_NP_TX) begin
              npWr[s.hdr[6:5]] = 1'b1;
            end
            irqWr = s.hdr[4:0] == REG_IRQ;
          end
        end
        MS_RD_TA: begin
          // first turnaround bit: drive low, data follows
          next_s.oe = 1'b1;
          next_s.out = 1'b0;
          next_s.bitCnt = DATA_BITS;
          next_s.st = MS_RD_DATA;
        end
        MS_RD_DATA: begin
          if (s.bitCnt != 5'h00) begin
            next_s.out = s.shift[15];
            next_s.shift = {s.shift[14:0], 1'b0};
            next_s.bitCnt = s.bitCnt - 5'h01;
          end else begin
            next_s.oe = 1'b0;
            next_s.out = 1'b0;
            next_s.st = MS_PREAMBLE;
          end
        end
        default: begin
          next_s.st = MS_PREAMBLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s.st <= MS_PREAMBLE;
      s.mdcPrev <= 1'b0;
      s.preCnt <= 6'h00;
      s.bitCnt <= 5'h00;
      s.hdr <= 12'h000;
      s.shift <= 16'h0000;
      s.out <= 1'b0;
      s.oe <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign mdioOut = s.out;
  assign mdioOe = s.oe;

  // ==========================================================
  // registers
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    pnr_np_port u_np (
      .clk(clk),
      .rst_b(rst_b),
      .wrEn(npWr[p]),
      .wrData(wrVal),
      .pageSent(pageSent[p]),
      .npWord(npTxWord[p])
    );
  end

  pnr_irq_core u_irq (
    .clk(clk),
    .rst_b(rst_b),
    .stat(portStat),
    .wrEn(irqWr),
    .wrData(wrVal),
    .rdClr(rdClr),
    .irqReg(irqReg),
    .irqN(status_change_irq_n)
  );

  // ==========================================================
  // checks
  sequence s_taLow;
    !mdioOut;
  endsequence
  property p_taDrive;
    @(posedge clk) disable iff (!rst_b) $rose(mdioOe) |-> s_taLow;
  endproperty
  a_taDrive: assert property (p_taDrive) else $error("turnaround bit not driven low");
  property p_rsvdZero;
    @(posedge clk) disable iff (!rst_b)
      npTxWord[0].rsvd14 == 1'b0 && npTxWord[3].rsvd14 == 1'b0 && irqReg.rsvdHi == 3'h0 && irqReg.rsvdLo == 3'h0;
  endproperty
  a_rsvdZero: assert property (p_rsvdZero) else $error("reserved bit not zero");
  property p_portIsolated;
    @(posedge clk) disable iff (!rst_b) npWr[0] && !pageSent[1] |=> npTxWord[1] == $past(npTxWord[1]);
  endproperty
  a_portIsolated: assert property (p_portIsolated) else $error("write to port 0 changed port 1");
  property p_enWrite;
    @(posedge clk) disable iff (!rst_b) irqWr |=> irqReg[12:8] == $past(wrVal[12:8]);
  endproperty
  a_enWrite: assert property (p_enWrite) else $error("enable bits not written");
  property p_linkEnWrite;
    @(posedge clk) disable iff (!rst_b)
      irqWr |=> irqReg.enLink == $past(wrVal[12]) && (irqReg.fLink || !$past(irqReg.fLink));
  endproperty
  a_linkEnWrite: assert property (p_linkEnWrite) else $error("link enable not written");
  property p_duplexEnWrite;
    @(posedge clk) disable iff (!rst_b) irqWr |=> irqReg.enDuplex == $past(wrVal[11]);
  endproperty
  a_duplexEnWrite: assert property (p_duplexEnWrite) else $error("duplex enable not written");
  property p_anegEnWrite;
    @(posedge clk) disable iff (!rst_b) irqWr |=> irqReg.enAneg == $past(wrVal[10]);
  endproperty
  a_anegEnWrite: assert property (p_anegEnWrite) else $error("negotiation enable not written");
  property p_mauEnWrite;
    @(posedge clk) disable iff (!rst_b) irqWr |=> irqReg.enMau == $past(wrVal[9]);
  endproperty
  a_mauEnWrite: assert property (p_mauEnWrite) else $error("medium error enable not written");

  // ==========================================================
  // per-port word checks
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
    property p_resetWord;
      @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> npTxWord[p] == NP_RESET;
    endproperty
    a_resetWord: assert property (p_resetWord) else $error("port word not at reset value");
    property p_otherPort;
      @(posedge clk) disable iff (!rst_b)
        npWr[p] && !pageSent[(p + 1) % NUM_PORTS] |=> $stable(npTxWord[(p + 1) % NUM_PORTS]);
    endproperty
    a_otherPort: assert property (p_otherPort) else $error("write reached another port");
    property p_morePages;
      @(posedge clk) disable iff (!rst_b) npWr[p] |=> npTxWord[p].nextPage == $past(wrVal[15]);
    endproperty
    a_morePages: assert property (p_morePages) else $error("next-page bit not written");
    property p_pageKind;
      @(posedge clk) disable iff (!rst_b) npWr[p] |=> npTxWord[p].msgPage == $past(wrVal[13]);
    endproperty
    a_pageKind: assert property (p_pageKind) else $error("page kind not written");
    property p_comply;
      @(posedge clk) disable iff (!rst_b) npWr[p] |=> npTxWord[p].ack2 == $past(wrVal[12]);
    endproperty
    a_comply: assert property (p_comply) else $error("comply bit not written");
    property p_toggleOwn;
      @(posedge clk) disable iff (!rst_b) npWr[p] && !pageSent[p] |=> $stable(npTxWord[p].toggle);
    endproperty
    a_toggleOwn: assert property (p_toggleOwn) else $error("write moved toggle");
    property p_codeField;
      @(posedge clk) disable iff (!rst_b) npWr[p] |=> npTxWord[p].msgCode == $past(wrVal[10:0]);
    endproperty
    a_codeField: assert property (p_codeField) else $error("message code not written");
    property p_rsvdPort;
      @(posedge clk) disable iff (!rst_b) npTxWord[p].rsvd14 == 1'b0;
    endproperty
    a_rsvdPort: assert property (p_rsvdPort) else $error("reserved bit set");
  end

  // ==========================================================
  // frame engine checks
  sequence s_hdrEnd;
    mdcRise && s.st == MS_HEADER && s.bitCnt == HDR_BITS - 5'h01;
  endsequence
  sequence s_readHdr;
    s_hdrEnd ##0 (rdHit && hdrNext[11:10] == OP_READ);
  endsequence
  property p_shortPreamble;
    @(posedge clk) disable iff (!rst_b)
      mdcRise && s.st == MS_PREAMBLE && !mdioIn && s.preCnt != PREAMBLE_BITS |=> s.st == MS_PREAMBLE;
  endproperty
  a_shortPreamble: assert property (p_shortPreamble) else $error("frame after short preamble");
  property p_badStart;
    @(posedge clk) disable iff (!rst_b) mdcRise && s.st == MS_START && !mdioIn |=> s.st == MS_PREAMBLE;
  endproperty
  a_badStart: assert property (p_badStart) else $error("bad start bit accepted");
  property p_missIgnored;
    @(posedge clk) disable iff (!rst_b) s_hdrEnd ##0 !rdHit |=> s.st == MS_PREAMBLE && !mdioOe;
  endproperty
  a_missIgnored: assert property (p_missIgnored) else $error("foreign frame not ignored");
  property p_badOp;
    @(posedge clk) disable iff (!rst_b)
      s_hdrEnd ##0 (rdHit && hdrNext[11] == hdrNext[10]) |=> s.st == MS_PREAMBLE;
  endproperty
  a_badOp: assert property (p_badOp) else $error("unknown opcode not ignored");
  property p_readTurn;
    @(posedge clk) disable iff (!rst_b) s_readHdr |=> s.st == MS_RD_TA && !mdioOe;
  endproperty
  a_readTurn: assert property (p_readTurn) else $error("read missed turnaround");
  property p_readClrWhen;
    @(posedge clk) disable iff (!rst_b) rdClr |-> s_readHdr ##0 (hdrNext[4:0] == REG_IRQ);
  endproperty
  a_readClrWhen: assert property (p_readClrWhen) else $error("flags cleared without a read");
  property p_readClrDone;
    @(posedge clk) disable iff (!rst_b) s_readHdr ##0 (hdrNext[4:0] == REG_IRQ) |-> rdClr;
  endproperty
  a_readClrDone: assert property (p_readClrDone) else $error("read did not clear flags");
  property p_irqSnapshot;
    @(posedge clk) disable iff (!rst_b) s_readHdr ##0 (hdrNext[4:0] == REG_IRQ) |=> s.shift == $past(irqReg);
  endproperty
  a_irqSnapshot: assert property (p_irqSnapshot) else $error("read data not shared register");
  property p_unmapped;
    @(posedge clk) disable iff (!rst_b)
      s_readHdr ##0 (hdrNext[4:0] != REG_NP_TX && hdrNext[4:0] != REG_IRQ) |=> s.shift == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  sequence s_taDriven;
    mdioOe ##0 s_taLow;
  endsequence
  property p_taToData;
    @(posedge clk) disable iff (!rst_b) mdcRise && s.st == MS_RD_TA |=> s_taDriven ##0 s.bitCnt == DATA_BITS;
  endproperty
  a_taToData: assert property (p_taToData) else $error("turnaround did not load count");
  property p_oeOnlyData;
    @(posedge clk) disable iff (!rst_b) mdioOe |-> s.st == MS_RD_DATA;
  endproperty
  a_oeOnlyData: assert property (p_oeOnlyData) else $error("line driven outside data");
  property p_release;
    @(posedge clk) disable iff (!rst_b)
      mdcRise && s.st == MS_RD_DATA && s.bitCnt == 5'h00 |=> !mdioOe && s.st == MS_PREAMBLE;
  endproperty
  a_release: assert property (p_release) else $error("line not released");
  property p_wrTa;
    @(posedge clk) disable iff (!rst_b)
      mdcRise && s.st == MS_WR_TA && s.bitCnt == TA_BITS - 5'h01 |=> s.st == MS_WR_DATA && s.bitCnt == 5'h00;
  endproperty
  a_wrTa: assert property (p_wrTa) else $error("write turnaround length wrong");
  property p_wrAtEnd;
    @(posedge clk) disable iff (!rst_b)
      (|npWr) || irqWr |-> mdcRise && s.st == MS_WR_DATA && s.bitCnt == DATA_BITS - 5'h01;
  endproperty
  a_wrAtEnd: assert property (p_wrAtEnd) else $error("partial word written");
  property p_oneTarget;
    @(posedge clk) disable iff (!rst_b) $onehot0({npWr, irqWr});
  endproperty
  a_oneTarget: assert property (p_oneTarget) else $error("write hit two registers");
endmodule
`default_nettype wire

// file: rtl/pnr_pkg.sv
// shared constants, register layouts and state types for the next-page and interrupt register bank
`default_nettype none
package pnr_pkg;
  // ==========================================================
  // map and reset values
  localparam int NUM_PORTS = 4;
  localparam logic [4:0] REG_NP_TX = 5'h07;
  localparam logic [4:0] REG_IRQ = 5'h10;
  localparam logic [15:0] NP_RESET = 16'h2001;
  localparam logic [15:0] NP_WR_MASK = 16'hB7FF;
  localparam logic [15:0] IRQ_WR_MASK = 16'h1F00;
  localparam logic [15:0] IRQ_RESET = 16'h0000;
  // ==========================================================
  // management frame
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [4:0] HDR_BITS = 5'h0C;
  localparam logic [4:0] TA_BITS = 5'h02;
  localparam logic [4:0] DATA_BITS = 5'h10;
  // ==========================================================
  // register layouts
  typedef struct packed {
    logic nextPage;
    logic rsvd14;
    logic msgPage;
    logic ack2;
    logic toggle;
    logic [10:0] msgCode;
  } pnr_np_t;
  typedef struct packed {
    logic [2:0] rsvdHi;
    logic enLink;
    logic enDuplex;
    logic enAneg;
    logic enMau;
    logic enGlobal;
    logic [2:0] rsvdLo;
    logic fLink;
    logic fDuplex;
    logic fAneg;
    logic fMau;
    logic fGlobal;
  } pnr_irq_t;
  typedef struct packed {
    logic [NUM_PORTS-1:0] linkUp;
    logic [NUM_PORTS-1:0] fullDuplex;
    logic [NUM_PORTS-1:0] anegEvent;
    logic [NUM_PORTS-1:0] mauErrEvent;
  } pnr_port_stat_t;
  typedef struct packed {
    pnr_irq_t r;
    logic [NUM_PORTS-1:0] prevLink;
    logic [NUM_PORTS-1:0] prevDuplex;
    logic primed;
    logic irqN;
  } pnr_irq_state_t;
  // ==========================================================
  // management slave
  typedef enum logic [2:0] {
    MS_PREAMBLE,
    MS_START,
    MS_HEADER,
    MS_WR_TA,
    MS_WR_DATA,
    MS_RD_TA,
    MS_RD_DATA
  } pnr_mstate_t;
  typedef struct packed {
    pnr_mstate_t st;
    logic mdcPrev;
    logic [5:0] preCnt;
    logic [4:0] bitCnt;
    logic [11:0] hdr;
    logic [15:0] shift;
    logic out;
    logic oe;
  } pnr_mdio_state_t;
endpackage
`default_nettype wire

// file: rtl/pnr_np_port.sv
// one port's outgoing next-page code word
`timescale 1ns/1ps
`default_nettype none
module pnr_np_port
  import pnr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  input wire logic pageSent,
  output var pnr_np_t npWord
);
  pnr_np_t st;
  pnr_np_t next_st;

  always_comb begin
    next_st = st;
    if (wrEn) begin
      // toggle and reserved bit keep their own value
      next_st = pnr_np_t'((wrData & NP_WR_MASK) | (st & ~NP_WR_MASK));
    end
    if (pageSent) begin
      next_st.toggle = ~st.toggle;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= pnr_np_t'(NP_RESET);
    end else begin
      st <= next_st;
    end
  end

  assign npWord = st;

  // ==========================================================
  // checks
  property p_npReset;
    @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> npWord == NP_RESET;
  endproperty
  a_npReset: assert property (p_npReset) else $error("next-page word not at reset value");
  property p_toggleHeld;
    @(posedge clk) disable iff (!rst_b) wrEn && !pageSent |=> npWord.toggle == $past(npWord.toggle);
  endproperty
  a_toggleHeld: assert property (p_toggleHeld) else $error("write changed toggle");
  property p_toggleFlip;
    @(posedge clk) disable iff (!rst_b) pageSent |=> npWord.toggle != $past(npWord.toggle);
  endproperty
  a_toggleFlip: assert property (p_toggleFlip) else $error("toggle did not flip");
  property p_npWrite;
    @(posedge clk) disable iff (!rst_b)
      wrEn |=> npWord.nextPage == $past(wrData[15]) && npWord.msgPage == $past(wrData[13])
        && npWord.ack2 == $past(wrData[12]) && npWord.msgCode == $past(wrData[10:0]);
  endproperty
  a_npWrite: assert property (p_npWrite) else $error("write did not land in next-page word");
endmodule
`default_nettype wire

// file: rtl/pnr_irq_core.sv
// shared interrupt status and enable register with change detection
`timescale 1ns/1ps
`default_nettype none
module pnr_irq_core
  import pnr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire pnr_port_stat_t stat,
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  input wire logic rdClr,
  output var pnr_irq_t irqReg,
  output var logic irqN
);
  pnr_irq_state_t st;
  pnr_irq_state_t next_st;
  logic evLink;
  logic evDuplex;
  logic evAneg;
  logic evMau;

  always_comb begin
    // no change is reported for levels seen in the first cycle after reset
    evLink = st.primed & (|(stat.linkUp ^ st.prevLink));
    evDuplex = st.primed & (|(stat.fullDuplex ^ st.prevDuplex));
    evAneg = |stat.anegEvent;
    evMau = |stat.mauErrEvent;
    next_st = st;
    next_st.prevLink = stat.linkUp;
    next_st.prevDuplex = stat.fullDuplex;
    next_st.primed = 1'b1;
    if (wrEn) begin
      next_st.r = pnr_irq_t'((wrData & IRQ_WR_MASK) | (st.r & ~IRQ_WR_MASK));
    end
    if (rdClr) begin
      next_st.r.fLink = 1'b0;
      next_st.r.fDuplex = 1'b0;
      next_st.r.fAneg = 1'b0;
      next_st.r.fMau = 1'b0;
      next_st.r.fGlobal = 1'b0;
    end
    // sets come after the read clear so a coincident event survives
    if (evLink) begin
      next_st.r.fLink = 1'b1;
    end
    if (evDuplex) begin
      next_st.r.fDuplex = 1'b1;
    end
    if (evAneg) begin
      next_st.r.fAneg = 1'b1;
    end
    if (evMau) begin
      next_st.r.fMau = 1'b1;
    end
    if (evLink || evDuplex || evAneg || evMau) begin
      next_st.r.fGlobal = 1'b1;
    end
    next_st.irqN = !(next_st.r.enGlobal
      && (|({next_st.r.enLink, next_st.r.enDuplex, next_st.r.enAneg, next_st.r.enMau}
      & {next_st.r.fLink, next_st.r.fDuplex, next_st.r.fAneg, next_st.r.fMau})));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st.r <= pnr_irq_t'(IRQ_RESET);
      st.prevLink <= '0;
      st.prevDuplex <= '0;
      st.primed <= 1'b0;
      st.irqN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign irqReg = st.r;
  assign irqN = st.irqN;

  // ==========================================================
  // checks
  property p_linkSet;
    @(posedge clk) disable iff (!rst_b) evLink |=> irqReg.fLink;
  endproperty
  a_linkSet: assert property (p_linkSet) else $error("link change flag not set");
  property p_globalSet;
    @(posedge clk) disable iff (!rst_b) (evLink || evDuplex || evAneg || evMau) |=> irqReg.fGlobal;
  endproperty
  a_globalSet: assert property (p_globalSet) else $error("global flag not set");
  property p_readClear;
    @(posedge clk) disable iff (!rst_b)
      rdClr && !(evLink || evDuplex || evAneg || evMau) |=> irqReg[4:0] == 5'h00;
  endproperty
  a_readClear: assert property (p_readClear) else $error("read did not clear flags");
  property p_pinOn;
    @(posedge clk) disable iff (!rst_b)
      irqReg.enGlobal && (|(irqReg[12:9] & irqReg[4:1])) |-> !irqN;
  endproperty
  a_pinOn: assert property (p_pinOn) else $error("enabled flag not on interrupt pin");
  property p_pinGated;
    @(posedge clk) disable iff (!rst_b) !irqReg.enGlobal |-> irqN;
  endproperty
  a_pinGated: assert property (p_pinGated) else $error("interrupt asserted with global enable off");
endmodule
`default_nettype wire

// file: dv/pnr_mgmt_master.sv
// management-bus master standing in for the switch controller
`timescale 1ns/1ps
`default_nettype none
module pnr_mgmt_master
  import pnr_pkg::*;
(
  input wire logic clk,
  input wire logic mdioOut,
  input wire logic mdioOe,
  output var logic mdc,
  output wire logic mdioLine
);
  logic drvOe;
  logic drvBit;
  // ==========================================================
  // wire resolution: pull-up when nobody drives
  assign mdioLine = mdioOe ? mdioOut : (drvOe ? drvBit : 1'b1);
  initial begin
    mdc = 1'b0;
    drvOe = 1'b0;
    drvBit = 1'b1;
  end
  // ==========================================================
  // one frame; mdc stays low between frames, half >= 2 clk
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd, input int half, output logic [15:0] rd, output logic taBit);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    taBit = 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      // release the line from the turnaround of a read onward
      drvOe <= !(op == OP_READ && i >= 46);
      drvBit <= bits[63 - i];
      repeat (half) @(posedge clk);
      mdc <= 1'b1;
      repeat (half) @(posedge clk);
      if (i == 46) taBit = mdioLine;
      if (i >= 47 && i <= 62) rd = {rd[14:0], mdioLine};
      mdc <= 1'b0;
    end
    @(posedge clk);
    drvOe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/pnr_nextpage_irq_regs_test.sv
// self-checking bench for the next-page and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module pnr_nextpage_irq_regs_test;
  import pnr_pkg::*;
  logic clk;
  logic rst_b;
  logic mdc;
  logic mdioLine;
  logic mdioOut;
  logic mdioOe;
  logic [3:0] pageSent;
  pnr_port_stat_t portStat;
  pnr_np_t [3:0] npTxWord;
  pnr_irq_t irqReg;
  logic irqN;
  int n_errors;
  int compares;
  int cycles;
  int seed;
  logic [15:0] rd;
  logic [15:0] wd;
  logic [15:0] en;
  logic [15:0] fl;
  logic [15:0] model [4];

  pnr_nextpage_irq_regs #(.PHY_BASE(5'h00)) u_pnr_nextpage_irq_regs (.clk(clk), .rst_b(rst_b), .mdc(mdc),
    .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe), .pageSent(pageSent), .portStat(portStat),
    .npTxWord(npTxWord), .irqReg(irqReg), .status_change_irq_n(irqN));
  pnr_mgmt_master u_pnr_mgmt_master (.clk(clk), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc),
    .mdioLine(mdioLine));

  always #2.5 clk = !clk;
  // ==========================================================
  // helpers
  function automatic logic [15:0] np_next(input logic [15:0] old, input logic [15:0] w);
    return (old & 16'h0800) | (w & NP_WR_MASK);
  endfunction
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic mwr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] w);
    logic [15:0] d;
    logic t;
    u_pnr_mgmt_master.frame(OP_WRITE, phy, ra, w, 3, d, t);
    repeat (2) @(posedge clk);
  endtask
  // random mdc pace, prompt to slow
  task automatic mrd(input logic [4:0] phy, input logic [4:0] ra, output logic [15:0] d);
    logic t;
    u_pnr_mgmt_master.frame(OP_READ, phy, ra, 16'h0000, 2 + ($random(seed) & 3), d, t);
    if (phy[4:2] == 3'h0) chk({15'h0, t}, 16'h0000);
  endtask
  task automatic fire(input int s, input int p);
    @(posedge clk);
    case (s)
      0: portStat.linkUp <= portStat.linkUp ^ (4'h1 << p);
      1: portStat.fullDuplex <= portStat.fullDuplex ^ (4'h1 << p);
      2: portStat.anegEvent <= 4'h1 << p;
      default: portStat.mauErrEvent <= 4'h1 << p;
    endcase
    @(posedge clk);
    portStat.anegEvent <= 4'h0;
    portStat.mauErrEvent <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      final_report();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 95;
    clk = 1'b0;
    rst_b = 1'b0;
    pageSent = 4'h0;
    portStat = '0;
    n_errors = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk(irqReg, IRQ_RESET);
    chk({15'h0, irqN}, 16'h0001);
    for (int p = 0; p < 4; p++) begin
      model[p] = NP_RESET;
      chk(npTxWord[p], NP_RESET);
      mrd(5'(p), REG_NP_TX, rd);
      chk(rd, NP_RESET);
    end
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 4; p++) begin
        wd = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($random(seed));
        mwr(5'(p), REG_NP_TX, wd);
        model[p] = np_next(model[p], wd);
        for (int q = 0; q < 4; q++) chk(npTxWord[q], model[q]);
        mrd(5'(p), REG_NP_TX, rd);
        chk(rd, model[p]);
      end
    end
    // toggle is flipped by the device only
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      pageSent <= 4'h1 << p;
      @(posedge clk);
      pageSent <= 4'h0;
      repeat (2) @(posedge clk);
      model[p] = model[p] ^ 16'h0800;
      for (int q = 0; q < 4; q++) chk(npTxWord[q], model[q]);
    end
    mrd(5'h03, REG_NP_TX, rd);
    chk(rd, model[3]);
    mwr(5'h03, REG_NP_TX, 16'h0000);
    chk(npTxWord[3], np_next(model[3], 16'h0000));
    mrd(5'h00, 5'h05, rd);
    chk(rd, 16'h0000);
    mrd(5'h04, REG_IRQ, rd);
    chk(rd, 16'hFFFF);
    mwr(5'h01, REG_IRQ, 16'hFFFF);
    mrd(5'h02, REG_IRQ, rd);
    chk(rd, IRQ_WR_MASK);
    // each source: own enable on, own enable masked, global off
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 3; m++) begin
        en = (m == 0) ? IRQ_WR_MASK : (m == 1) ? (IRQ_WR_MASK & ~(16'h1000 >> s)) : (16'h1000 >> s);
        mwr(5'(s), REG_IRQ, en);
        fire(s, $random(seed) & 3);
        fl = (16'h0010 >> s) | 16'h0001;
        chk(irqReg, en | fl);
        chk({15'h0, irqN}, (m == 0) ? 16'h0000 : 16'h0001);
        mrd(5'(3 - s), REG_IRQ, rd);
        chk(rd, en | fl);
        chk(irqReg, en);
        chk({15'h0, irqN}, 16'h0001);
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
